//--- logic/oscsel_pkg.sv
// Purpose: shared constants for the oscillator select and aux control block
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: offsets are byte addresses on the register bus
package oscsel_pkg;
  localparam int ADDR_W = 12;
  // register byte addresses
  // aux register index is not word aligned: byte address is four times it
  localparam logic [7:0] AUX_CTRL_IDX = 8'h9E;
  localparam logic [11:0] AUX_CTRL_ADDR = 12'h278;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h0A0;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h0A4;
  localparam logic [11:0] MODE_ADDR = 12'h0A8;
  // aux control field positions
  localparam int B_IN_STAT = 0;
  localparam int B_OUT_LATCH = 1;
  localparam int B_DIV_EN = 2;
  localparam int B_SMBUS = 3;
  localparam int B_PAIR_SEL = 4;
  localparam int B_GND_P3 = 5;
  localparam int B_GND_P4 = 6;
  localparam int B_STRETCH = 7;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_WMASK = 8'hFE;
  // interrupt status bits
  localparam int IRQ_FALL = 0;
  localparam int IRQ_RISE = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // fuse word: bit 0 picks the oscillator
  localparam int FUSE_OSC_BIT = 0;
  localparam logic FUSE_FAST_RES = 1'b0;
  // on-chip oscillator nominal rate
  localparam int INT_OSC_MHZ = 4;
  localparam int DIV_W = 2;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam int SYNC_N = 3;
  localparam logic [2:0] SYNC_RESET = 3'h7;
endpackage

//--- logic/oscsel_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to pclk
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module oscsel_sync (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic din, // asynchronous level
  output logic dout // filtered level
);
  import oscsel_pkg::*;
  logic [SYNC_N-1:0] stage;
  logic agree;

  // stage 0 only feeds stage 1; filter looks at stages 1 and 2
  assign agree = (stage[1] == stage[2]);

  // shift chain, resets high to match the weak pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= SYNC_RESET;
      dout <= 1'b1;
    end else begin
      stage <= {stage[SYNC_N-2:0], din};
      if (agree) begin
        dout <= stage[2];
      end
    end
  end
endmodule

//--- logic/oscsel_top.sv
// Purpose: oscillator mode select and auxiliary control register
// Assumes: apb slave on pclk; on-chip oscillator clock is int_osc_clk
// Notes: pin drivers and pad thresholds are plain selects to the pads
// Functional notes
// - fuse bit 0 picks mode: 0 fast resonator, 1 on-chip oscillator
// - on-chip mode runs from the internal 4 MHz oscillator
// - on-chip mode: input pin level read at bit 0, writes ignored
// - input pin edges in on-chip mode can raise an interrupt
// - on-chip mode: bit 1 latch drives output pin, reads the latch
// - on-chip mode: divided-clock enable puts oscillator divided by four on output pin
// - input status bit shows the pin only in on-chip mode, never written
// - stretch enable holds i2c clock low while receive buffer is full
// - port four ground select: 1 analog ref pin, 0 ground
// - port three ground select: 1 analog ref pin, 0 ground
// - pair select routes i2c to port four when set, port three when clear
// - smbus bit picks smbus thresholds, else schmitt thresholds
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module oscsel_top (
  input wire logic pclk, // system clock, 250 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [oscsel_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [7:0] fuse_word, // non-volatile configuration word
  input wire logic int_osc_clk, // on-chip oscillator clock
  input wire logic int_osc_resetn, // reset for oscillator domain
  input wire logic clock_input_pin, // level on the clock input pin
  output logic clock_input_pullup_en, // weak pull-up on input pin
  output logic clock_output_pin_o, // output pin drive value
  output logic clock_output_pin_oe, // output pin drive enable
  output logic osc_amp_en, // crystal amplifier across the pins
  output logic core_clk_sel_int, // core runs from on-chip oscillator
  input wire logic rx_buf_full, // i2c receive buffer full
  input wire logic i2c_scl_in, // i2c clock from the serial port
  output logic i2c_scl_hold, // hold i2c clock line low
  output logic i2c_on_port_four, // i2c routed to port four 1:0
  output logic i2c_on_port_three, // i2c routed to port three 7:6
  output logic smbus_thresholds, // smbus input thresholds on both pairs
  output logic port_four_gnd_ref, // port four 1:0 refer to analog pin
  output logic port_three_gnd_ref, // port three 7:6 refer to analog pin
  output logic irq // level interrupt
);
  import oscsel_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // mode capture
  logic fuse_int_mode;
  logic mode_valid;
  logic int_mode;

  // fuse is caught after reset release, never loaded by the reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_int_mode <= 1'b1;
      mode_valid <= 1'b0;
    end else if (!mode_valid) begin
      fuse_int_mode <= fuse_word[FUSE_OSC_BIT] != FUSE_FAST_RES;
      mode_valid <= 1'b1;
    end
  end
  assign int_mode = fuse_int_mode;
  assign core_clk_sel_int = int_mode;
  // amplifier only in resonator mode, pins left to the crystal
  assign osc_amp_en = !int_mode;

  ////////////////////////////////////////////////////////////////////////
  // input pin synchroniser and edge events
  logic pin_sync;
  logic pin_prev;
  logic pin_fall;
  logic pin_rise;

  oscsel_sync u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(clock_input_pin),
    .dout(pin_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= pin_sync;
    end
  end
  // edges count only in on-chip mode, the pin is a clock otherwise
  // mode_valid gate: mode reads on-chip for one cycle before the fuse lands
  assign pin_fall = mode_valid && int_mode && pin_prev && !pin_sync;
  assign pin_rise = mode_valid && int_mode && !pin_prev && pin_sync;
  assign clock_input_pullup_en = int_mode;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  logic wr_en;
  logic rd_en;
  logic hit_aux;
  logic hit_stat;
  logic hit_mask;
  logic hit_mode;
  logic hit_any;

  assign hit_aux = (paddr == AUX_CTRL_ADDR);
  assign hit_stat = (paddr == IRQ_STAT_ADDR);
  assign hit_mask = (paddr == IRQ_MASK_ADDR);
  assign hit_mode = (paddr == MODE_ADDR);
  assign hit_any = hit_aux | hit_stat | hit_mask | hit_mode;
  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign wr_en = psel && penable && pwrite && hit_any;
  assign rd_en = psel && penable && !pwrite;

  ////////////////////////////////////////////////////////////////////////
  // aux control register
  logic [7:0] aux;
  logic [7:0] aux_rd;

  // bit 0 is never stored; writes to it vanish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux <= AUX_RESET;
    end else if (wr_en && hit_aux) begin
      aux <= pwdata[7:0] & AUX_WMASK;
    end
  end
  // status bit reads the pin in on-chip mode, zero otherwise
  assign aux_rd = {aux[7:1], int_mode & pin_sync};

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = {pin_rise, pin_fall};
  assign irq_clr = (wr_en && hit_stat) ? pwdata[IRQ_W-1:0] : IRQ_RESET;

  // a set in the same cycle as its clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_en && hit_mask) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // read data register
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_aux) begin
      next_prdata = {24'h00_0000, aux_rd};
    end else if (hit_stat) begin
      next_prdata = {30'h0000_0000, irq_stat};
    end else if (hit_mask) begin
      next_prdata = {30'h0000_0000, irq_mask};
    end else if (hit_mode) begin
      next_prdata = {31'h0000_0000, int_mode};
    end
  end

  // read data is captured in the setup cycle so it stands in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divide-by-four on the oscillator's own clock
  logic [DIV_W-1:0] div_cnt;
  logic div_en_s1;
  logic div_en_s2;
  logic div_clk;

  // free-running so the output phase needs no restart logic
  always_ff @(posedge int_osc_clk or negedge int_osc_resetn) begin
    if (!int_osc_resetn) begin
      div_cnt <= DIV_RESET;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // enable crosses into the oscillator domain as a level
  always_ff @(posedge int_osc_clk or negedge int_osc_resetn) begin
    if (!int_osc_resetn) begin
      div_en_s1 <= 1'b0;
      div_en_s2 <= 1'b0;
      div_clk <= 1'b0;
    end else begin
      div_en_s1 <= aux[B_DIV_EN];
      div_en_s2 <= div_en_s1;
      div_clk <= div_en_s2 & div_cnt[DIV_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output pin, serial routing and pad controls
  // divided clock takes the pin over the latch; pin free in resonator mode
  assign clock_output_pin_oe = int_mode;
  assign clock_output_pin_o = !int_mode ? 1'b0 :
    (aux[B_DIV_EN] ? div_clk : aux[B_OUT_LATCH]);

  // stretch only when enabled and buffer full
  assign i2c_scl_hold = aux[B_STRETCH] & rx_buf_full & !i2c_scl_in
    | aux[B_STRETCH] & rx_buf_full;
  assign port_four_gnd_ref = aux[B_GND_P4];
  assign port_three_gnd_ref = aux[B_GND_P3];
  assign i2c_on_port_four = aux[B_PAIR_SEL];
  assign i2c_on_port_three = !aux[B_PAIR_SEL];
  assign smbus_thresholds = aux[B_SMBUS];
endmodule

//--- sim/oscsel_props.sv
// Purpose: port checks for the oscillator select block
// Assumes: zero wait apb on pclk
// Notes: aux fields are seen through their pad outputs
`timescale 1ns/1ps
module oscsel_props
  import oscsel_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [oscsel_pkg::ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic rx_buf_full, // rx full
  input wire logic core_clk_sel_int, // on-chip mode
  input wire logic osc_amp_en, // amplifier
  input wire logic clock_input_pullup_en, // pull-up
  input wire logic clock_output_pin_oe, // out enable
  input wire logic i2c_scl_hold, // stretch
  input wire logic i2c_on_port_four, // pair four
  input wire logic i2c_on_port_three, // pair three
  input wire logic smbus_thresholds, // thresholds
  input wire logic port_four_gnd_ref, // ref four
  input wire logic port_three_gnd_ref // ref three
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // taken write to the aux register
  wire wr_aux = psel && penable && pwrite && paddr == AUX_CTRL_ADDR;
  sequence s_str;
    wr_aux && pwdata[B_STRETCH] ##1 rx_buf_full;
  endsequence
  //////////////////////////////////////////////////////////////////
  AST_MODE: assert property (osc_amp_en != core_clk_sel_int)
    else $error("amp and mode agree");
  AST_PULL: assert property (core_clk_sel_int |->
    clock_input_pullup_en && clock_output_pin_oe) else $error("pin setup");
  AST_NOOE: assert property (!core_clk_sel_int |->
    !clock_output_pin_oe) else $error("output driven in resonator mode");
  AST_HOLD: assert property (i2c_scl_hold |-> rx_buf_full)
    else $error("stretch without full buffer");
  AST_STR: assert property (s_str |-> i2c_scl_hold)
    else $error("no stretch");
  AST_G4: assert property (wr_aux |=>
    port_four_gnd_ref == $past(pwdata[B_GND_P4])) else $error("ref four");
  AST_G3: assert property (wr_aux |=>
    port_three_gnd_ref == $past(pwdata[B_GND_P3])) else $error("ref three");
  AST_PAIR: assert property (wr_aux |=>
    i2c_on_port_four == $past(pwdata[B_PAIR_SEL]) &&
    i2c_on_port_three != i2c_on_port_four) else $error("pair route");
  AST_SMB: assert property (wr_aux |=>
    smbus_thresholds == $past(pwdata[B_SMBUS])) else $error("thresholds");
endmodule
bind oscsel_top oscsel_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .rx_buf_full, .core_clk_sel_int, .osc_amp_en,
  .clock_input_pullup_en, .clock_output_pin_oe, .i2c_scl_hold,
  .i2c_on_port_four, .i2c_on_port_three, .smbus_thresholds,
  .port_four_gnd_ref, .port_three_gnd_ref);

//--- sim/oscsel_src.sv
// Purpose: far side clock sources and input pin level
// Assumes: resonator mode means an external clock on the input pin
// Notes: behavioural, free running
`timescale 1ns/1ps
module oscsel_src (
  input wire logic hs_mode, // external clock drives the pin
  input wire logic btn, // pin level in on-chip mode
  output logic osc_clk, // on-chip oscillator
  output logic pin // clock input pin level
);
  logic ext_clk = 1'b0;
  initial osc_clk = 1'b0;
  // 4 MHz internal source, 20 MHz external drive
  always #125 osc_clk = !osc_clk;
  always #25 ext_clk = !ext_clk;
  assign pin = hs_mode ? ext_clk : btn;
endmodule

//--- sim/testbench.sv
// Purpose: scenario bench for the oscillator select block
// Assumes: apb answers with zero wait, still waited for
// Notes: one task per scenario
`timescale 1ns/1ps
module testbench;
  import oscsel_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [7:0] fuse_word = 8'hFF;
  logic rx_buf_full = 0, btn = 1, err;
  logic pready, pslverr, osc_clk, pin, pull, oo, ooe, amp, csel, hold;
  logic p4, p3, smb, g4, g3, irq;
  int errors = 0, cmp_count = 0, cyc = 0;
  oscsel_src u_src (.hs_mode(!fuse_word[0]), .btn, .osc_clk, .pin);
  oscsel_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fuse_word, .int_osc_clk(osc_clk),
    .int_osc_resetn(presetn), .clock_input_pin(pin),
    .clock_input_pullup_en(pull), .clock_output_pin_o(oo),
    .clock_output_pin_oe(ooe), .osc_amp_en(amp), .core_clk_sel_int(csel),
    .rx_buf_full, .i2c_scl_in(1'b1), .i2c_scl_hold(hold),
    .i2c_on_port_four(p4), .i2c_on_port_three(p3), .smbus_thresholds(smb),
    .port_four_gnd_ref(g4), .port_three_gnd_ref(g3), .irq);
  // clock and hang guard, ceiling well above the run length
  always #2 pclk = !pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////
  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rst(input logic b);
    @(posedge pclk);
    presetn <= 0;
    fuse_word <= {7'h7F, b};
    repeat (12) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////
  task t_reset();
    rst(1);
    apb(0, AUX_CTRL_ADDR, 0);
    chk("aux", 32'h01, r);
    apb(0, MODE_ADDR, 0);
    chk("mode", 32'h01, r);
    chk("pins", 4'b1101, {pull, csel, amp, ooe});
  endtask
  task t_fields();
    rx_buf_full <= 1;
    apb(1, AUX_CTRL_ADDR, 32'hFE);
    apb(0, AUX_CTRL_ADDR, 0);
    chk("aux", 32'hFF, r);
    chk("pads", 6'b110111, {hold, p4, p3, smb, g4, g3});
    apb(1, AUX_CTRL_ADDR, 32'h01);
    apb(0, AUX_CTRL_ADDR, 0);
    chk("aux", 32'h01, r);
    chk("pads", 6'b001000, {hold, p4, p3, smb, g4, g3});
  endtask
  task t_out();
    int n;
    logic last;
    n = 0;
    apb(1, AUX_CTRL_ADDR, 32'h02);
    // write lands at the edge the task returns on; look one edge later
    @(posedge pclk);
    chk("out pin", 1, oo);
    apb(1, AUX_CTRL_ADDR, 32'h06);
    last = oo;
    // 3000 ns at a 1000 ns divided period
    repeat (750) begin
      @(posedge pclk);
      if (oo && !last) n++;
      last = oo;
    end
    chk("div rises", 1, n inside {[2:4]});
    apb(1, AUX_CTRL_ADDR, 32'h00);
    @(posedge pclk);
    chk("out pin", 0, oo);
  endtask
  task t_irq();
    apb(1, IRQ_MASK_ADDR, 32'h01);
    btn <= 0;
    repeat (8) @(posedge pclk);
    chk("irq", 1, irq);
    apb(0, AUX_CTRL_ADDR, 0);
    chk("aux", 32'h00, r);
    apb(0, IRQ_STAT_ADDR, 0);
    chk("stat", 32'h01, r);
    apb(1, IRQ_STAT_ADDR, 32'h01);
    @(posedge pclk);
    chk("irq", 0, irq);
    apb(0, 12'h0FC, 0);
    chk("slverr", 1, err);
  endtask
  task t_hs();
    rst(0);
    apb(0, MODE_ADDR, 0);
    chk("mode", 32'h00, r);
    chk("amp oe", 4'b0010, {pull, csel, amp, ooe});
    apb(1, AUX_CTRL_ADDR, 32'h02);
    apb(0, AUX_CTRL_ADDR, 0);
    chk("aux", 32'h02, r);
    chk("out pin", 0, oo);
  endtask
  initial begin
    t_reset();
    t_fields();
    t_out();
    t_irq();
    t_hs();
    summarize();
  end
endmodule
